// ---- design/host_printer_port_glue.v ----
// Glue between the DSP parallel bus and the host printer port
`timescale 1ns/1ns
`include "host_glue_consts.vh"

// Contract
// R1: A DSP access is recognised from the bus strobe together with address lines 23 down to 20.
// R2: While host disconnect is high the interrupt and ready pins are released (not driven).
// R3: Five decode selects plus ready, interrupt and transceiver enable are provided.
// R4: With demonstration select high the user I/O and boot selects drive a tri-colour lamp.
// R5: Bytes pass between printer data lines and DSP data bus through a steered transceiver.
// R6: In bidirectional mode both directions carry full bytes.
// R7: In unidirectional mode host-to-DSP carries bytes and DSP-to-host carries nibbles on status lines.
// R8: A host reset command restarts the DSP so it can bootload over the host link.
// R9: A falling host byte strobe pulses the host request interrupt.
// R10: An access to the host port asserts host acknowledge and holds ready high to stall the DSP.
// R11: A rising host byte strobe during a stall drops ready so the DSP cycle completes.
// R12: Addresses from the host base to the top of the map are host interface accesses.
// R13: The host byte strobe passes two flip-flops before its edges are used.
module host_printer_port_glue #(
  parameter INT_PULSE = `INT_PULSE_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq,
  // DSP parallel bus
  input wire dspStrobe_n,
  input wire dspRead,
  input wire [23:0] dspAddr,
  input wire [7:0] dspDataIn,
  output reg [7:0] dspDataOut,
  output reg dspDataOe,
  output reg readyOut,
  output reg readyOe,
  output reg host_request_interrupt_n,
  output reg hostRequestInterruptOe,
  output reg dspReset_n,
  // Decode selects and transceiver steering
  output reg user_io_read_select_n,
  output reg user_io_write_select_n,
  output reg userIoSelect_n,
  output reg userMemSelect_n,
  output reg bootSelect_n,
  output reg transceiverEnable_n,
  output reg transceiverToDsp,
  // Printer port side
  input wire host_byte_strobe,
  input wire hostInit_n,
  input wire hostDisconnect,
  input wire demonstration_select,
  input wire [7:0] lptDataIn,
  output reg [7:0] lptDataOut,
  output reg lptDataOe,
  output reg [3:0] statusNibble,
  output reg host_port_acknowledge_n
);

  // ----------------------------------------------------------------
  // Host access state machine
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_STALL = 3'b010;
  localparam ST_RELEASE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [`EV_WIDTH-1:0] irqStat;
  reg [`EV_WIDTH-1:0] irqEn;
  reg [15:0] xferCount;
  reg [7:0] pulseCount;
  reg accessRead;

  wire [1:0] syncLevel;
  wire [1:0] syncRise;
  wire [1:0] syncFall;
  wire strobeLevel;
  wire strobeRise;
  wire strobeFall;
  wire initLevel;
  wire initRise;
  wire dspActive;
  wire hostHit;
  wire [3:0] bank;
  wire wbReq;
  wire wbWrite;
  wire [`EV_WIDTH-1:0] events;
  wire [`EV_WIDTH-1:0] clearMask;
  wire [`STAT_WIDTH-1:0] statusWord;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function isHostAddr;
    input [23:0] addr;
    begin
      isHostAddr = (addr >= `HOST_BASE) && (addr <= `HOST_TOP);
    end
  endfunction

  function [31:0] padWord;
    input [15:0] value;
    begin
      padWord = {16'h0000, value};
    end
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers for host strobe and host init
  // ----------------------------------------------------------------
  edge_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async({hostInit_n, host_byte_strobe}),
    .level(syncLevel),
    .rise(syncRise),
    .fall(syncFall)
  ); // R13

  assign strobeLevel = syncLevel[0];
  assign strobeRise = syncRise[0];
  assign strobeFall = syncFall[0];
  assign initLevel = syncLevel[1];
  assign initRise = syncRise[1];

  assign bank = dspAddr[23:20];
  assign dspActive = !dspStrobe_n; // R1
  assign hostHit = dspActive && (bank == `BANK_HOST) && isHostAddr(dspAddr); // R12

  // ----------------------------------------------------------------
  // Host access sequencing
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (hostHit) begin
          next_state = ST_STALL; // R10
        end
      end
      ST_STALL: begin
        if (strobeRise) begin
          next_state = ST_RELEASE; // R11
        end else if (!dspActive) begin
          next_state = ST_IDLE;
        end
      end
      ST_RELEASE: begin
        // Wait for the DSP to end the cycle so one access gives one transfer
        if (!dspActive) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      accessRead <= 1'b0;
    end else if (ce) begin
      if (!initLevel) begin
        // Host reset abandons any half-done handshake
        state <= ST_IDLE;
      end else begin
        state <= next_state;
      end
      if (state == ST_IDLE && hostHit) begin
        accessRead <= dspRead;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready, acknowledge and interrupt pins
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readyOut <= 1'b0;
      readyOe <= 1'b0;
      host_request_interrupt_n <= 1'b1;
      hostRequestInterruptOe <= 1'b0;
      host_port_acknowledge_n <= 1'b1;
      pulseCount <= 8'h00;
    end else if (ce) begin
      // Ready high holds the DSP in wait states
      readyOut <= (next_state == ST_STALL) && initLevel; // R10 R11
      host_port_acknowledge_n <= !((next_state == ST_STALL) && initLevel); // R10
      readyOe <= !hostDisconnect; // R2
      hostRequestInterruptOe <= !hostDisconnect; // R2
      if (strobeFall) begin
        pulseCount <= INT_PULSE[7:0]; // R9
      end else if (pulseCount != 8'h00) begin
        pulseCount <= pulseCount - 8'h01;
      end
      host_request_interrupt_n <= !(strobeFall || pulseCount > 8'h01); // R9
    end
  end

  // ----------------------------------------------------------------
  // Address decode outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_io_read_select_n <= 1'b1;
      user_io_write_select_n <= 1'b1;
      userIoSelect_n <= 1'b1;
      userMemSelect_n <= 1'b1;
      bootSelect_n <= 1'b1;
    end else if (ce) begin
      user_io_read_select_n <= !(dspActive && bank == `BANK_USER_IO && dspRead); // R1 R3
      user_io_write_select_n <= !(dspActive && bank == `BANK_USER_IO && !dspRead); // R1 R3
      userMemSelect_n <= !(dspActive && bank == `BANK_USER_MEM); // R3
      if (demonstration_select) begin
        // Lamp colour comes from software; the two selects are not decoded
        userIoSelect_n <= !ctrl[`CTRL_LED_LO]; // R4
        bootSelect_n <= !ctrl[`CTRL_LED_HI]; // R4
      end else begin
        userIoSelect_n <= !(dspActive && bank == `BANK_USER_IO); // R3
        bootSelect_n <= !(dspActive && bank == `BANK_BOOT); // R3
      end
    end
  end

  // ----------------------------------------------------------------
  // Data path and transceiver steering
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transceiverEnable_n <= 1'b1;
      transceiverToDsp <= 1'b1;
      dspDataOut <= 8'h00;
      dspDataOe <= 1'b0;
      lptDataOut <= 8'h00;
      lptDataOe <= 1'b0;
      statusNibble <= 4'h0;
    end else if (ce) begin
      transceiverEnable_n <= (state == ST_IDLE); // R5
      transceiverToDsp <= accessRead; // R5
      if (state != ST_IDLE && accessRead) begin
        // Host to DSP is a full byte in either mode
        dspDataOut <= lptDataIn; // R6 R7
        dspDataOe <= 1'b1;
      end else begin
        dspDataOe <= 1'b0;
      end
      if (state != ST_IDLE && !accessRead) begin
        if (ctrl[`CTRL_BIDIR]) begin
          lptDataOut <= dspDataIn; // R6
          lptDataOe <= 1'b1;
        end else begin
          // Unidirectional ports only read back a nibble on status lines
          statusNibble <= dspDataIn[3:0]; // R7
          lptDataOe <= 1'b0;
        end
      end else begin
        lptDataOe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // DSP reset from host command
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dspReset_n <= 1'b0;
    end else if (ce) begin
      dspReset_n <= initLevel && !ctrl[`CTRL_SOFT_RESET]; // R8
    end
  end

  // ----------------------------------------------------------------
  // Wishbone register file
  // ----------------------------------------------------------------
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbReq && wb_we_i;
  assign events = {initRise, (state == ST_STALL) && strobeRise, strobeFall};
  assign clearMask = (wbWrite && wb_adr_i == `REG_IRQ_CLR && wb_sel_i[0]) ?
    wb_dat_i[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
  assign statusWord = {!initLevel, strobeLevel, demonstration_select,
    hostDisconnect, state == ST_RELEASE, state == ST_STALL};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl <= `CTRL_RESET;
      irqEn <= {`EV_WIDTH{1'b0}};
      irqStat <= {`EV_WIDTH{1'b0}};
      xferCount <= 16'h0000;
      irq <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wbReq;
      // A new event wins over a clear in the same cycle
      irqStat <= (irqStat & ~clearMask) | events;
      irq <= |(((irqStat & ~clearMask) | events) & irqEn);
      if (events[`EV_XFER_DONE]) begin
        xferCount <= xferCount + 16'h0001;
      end
      if (wbWrite && wb_sel_i[0]) begin
        case (wb_adr_i)
          `REG_CTRL: begin
            ctrl <= wb_dat_i[`CTRL_WIDTH-1:0];
          end
          `REG_IRQ_EN: begin
            irqEn <= wb_dat_i[`EV_WIDTH-1:0];
          end
          default: begin
          end
        endcase
      end
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `REG_CTRL: begin
            wb_dat_o <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl};
          end
          `REG_STATUS: begin
            wb_dat_o <= {{(32-`STAT_WIDTH){1'b0}}, statusWord};
          end
          `REG_IRQ_STAT: begin
            wb_dat_o <= {{(32-`EV_WIDTH){1'b0}}, irqStat};
          end
          `REG_IRQ_EN: begin
            wb_dat_o <= {{(32-`EV_WIDTH){1'b0}}, irqEn};
          end
          `REG_XFER_CNT: begin
            wb_dat_o <= padWord(xferCount);
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule // host_printer_port_glue

// ---- design/host_glue_consts.vh ----
// Constants for the DSP bus to printer port glue block
`ifndef HOST_GLUE_CONSTS_VH
`define HOST_GLUE_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the Wishbone slave)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_EN 8'h0C
`define REG_IRQ_CLR 8'h10
`define REG_XFER_CNT 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_BIDIR 0
`define CTRL_SOFT_RESET 1
`define CTRL_LED_LO 2
`define CTRL_LED_HI 3
`define CTRL_WIDTH 4
`define CTRL_RESET 4'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STAT_STALLED 0
`define STAT_RELEASE 1
`define STAT_DISCONNECT 2
`define STAT_LAMP_MODE 3
`define STAT_STROBE 4
`define STAT_INIT 5
`define STAT_WIDTH 6

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define EV_HOST_REQUEST 0
`define EV_XFER_DONE 1
`define EV_HOST_RESET 2
`define EV_WIDTH 3

// ----------------------------------------------------------------
// DSP address decode
// ----------------------------------------------------------------
`define BANK_BOOT 4'h0
`define BANK_USER_MEM 4'hC
`define BANK_USER_IO 4'hE
`define BANK_HOST 4'hF
`define HOST_BASE 24'hFF_F000
`define HOST_TOP 24'hFF_FFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define INT_PULSE_NS 40
`define INT_PULSE_CYCLES ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES 2

`endif

// ---- design/edge_sync.v ----
// Two-stage synchroniser with edge detection for slow external levels
`timescale 1ns/1ns
module edge_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [WIDTH-1:0] async,
  output reg [WIDTH-1:0] level,
  output reg [WIDTH-1:0] rise,
  output reg [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // ----------------------------------------------------------------
  // Stage1 feeds stage2 only; edges are taken from stage2 onward
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b1}};
      stage2 <= {WIDTH{1'b1}};
      level <= {WIDTH{1'b1}};
      rise <= {WIDTH{1'b0}};
      fall <= {WIDTH{1'b0}};
    end else if (ce) begin
      stage1 <= async;
      stage2 <= stage1;
      level <= stage2;
      rise <= stage2 & ~level;
      fall <= ~stage2 & level;
    end
  end

endmodule // edge_sync

// ---- dv/host_glue_assertions.sv ----
// Pin-level checks for the DSP bus to printer port glue
`timescale 1ns/1ns
`include "host_glue_consts.vh"
module host_glue_assertions #(
  parameter int INT_PULSE = 4
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire dspStrobe_n,
  input wire dspRead,
  input wire [23:0] dspAddr,
  input wire host_byte_strobe,
  input wire hostInit_n,
  input wire hostDisconnect,
  input wire demonstration_select,
  input wire readyOut,
  input wire readyOe,
  input wire hostRequestInterruptOe,
  input wire host_request_interrupt_n,
  input wire host_port_acknowledge_n,
  input wire user_io_read_select_n,
  input wire user_io_write_select_n,
  input wire userMemSelect_n,
  input wire bootSelect_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack is not a single pulse");
  chk_pins_float: assert property (hostDisconnect && ce |=> !readyOe && !hostRequestInterruptOe)
    else $error("ready or interrupt still driven while disconnected");
  // Reset sampled in the antecedent: the edge that releases reset still sees reset values next cycle
  chk_pins_drive: assert property (rst_n && !hostDisconnect && ce |=> readyOe && hostRequestInterruptOe)
    else $error("ready or interrupt released while connected");
  chk_host_stall: assert property ($fell(dspStrobe_n) && dspAddr >= `HOST_BASE && hostInit_n && ce
    |=> readyOut && !host_port_acknowledge_n) else $error("host access did not stall");
  chk_sync_release: assert property ($rose(host_byte_strobe) && readyOut && ce
    |=> readyOut [*2] ##[1:3] !readyOut) else $error("ready release timing wrong");
  chk_int_start: assert property ($fell(host_byte_strobe) && ce |-> ##[2:4] !host_request_interrupt_n)
    else $error("no interrupt pulse after strobe fall");
  chk_int_width: assert property ($fell(host_request_interrupt_n)
    |-> ##[INT_PULSE:INT_PULSE] $rose(host_request_interrupt_n)) else $error("interrupt pulse width wrong");
  chk_mem_select: assert property (!dspStrobe_n && dspAddr[23:20] == `BANK_USER_MEM && ce
    |=> !userMemSelect_n && bootSelect_n) else $error("user memory select wrong");
  chk_io_split: assert property (!dspStrobe_n && dspAddr[23:20] == `BANK_USER_IO && ce
    |=> user_io_read_select_n == !$past(dspRead) && user_io_write_select_n == $past(dspRead))
    else $error("user io read or write select wrong");
  chk_strobe_qual: assert property (dspStrobe_n && ce && !demonstration_select
    |=> userMemSelect_n && bootSelect_n && user_io_read_select_n && user_io_write_select_n)
    else $error("select active without bus strobe");
  cover property (readyOut ##1 !readyOut);
  cover property ($fell(host_request_interrupt_n));
  cover property (hostDisconnect ##1 !readyOe);
endmodule // host_glue_assertions

bind host_printer_port_glue host_glue_assertions #(.INT_PULSE(INT_PULSE)) chk (.clk, .rst_n, .ce, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .dspStrobe_n, .dspRead, .dspAddr, .host_byte_strobe, .hostInit_n, .hostDisconnect,
  .demonstration_select, .readyOut, .readyOe, .hostRequestInterruptOe, .host_request_interrupt_n,
  .host_port_acknowledge_n, .user_io_read_select_n, .user_io_write_select_n, .userMemSelect_n, .bootSelect_n);

// ---- dv/lpt_host_model.sv ----
// Behavioural printer port host driving strobe, init and data lines
`timescale 1ns/1ns
module lpt_host_model (
  input wire clk,
  input wire host_port_acknowledge_n,
  input wire [3:0] statusNibble,
  input wire [7:0] lptDataOut,
  output logic host_byte_strobe,
  output logic hostInit_n,
  output logic [7:0] lptDataIn
);
  // ----------------------------------------------------------------
  // Host handshakes
  // ----------------------------------------------------------------
  int slow = 2;
  initial begin
    host_byte_strobe = 1'b1;
    hostInit_n = 1'b1;
    lptDataIn = 8'h00;
  end
  task wait_ack(input logic lvl);
    // No local limit: only the bench watchdog may end a wait
    while (host_port_acknowledge_n !== lvl) @(posedge clk);
  endtask
  // Full byte inward in either port mode
  task send(input logic [7:0] d);
    @(posedge clk);
    lptDataIn <= d;
    host_byte_strobe <= 1'b0;
    wait_ack(1'b0);
    repeat (slow) @(posedge clk);
    host_byte_strobe <= 1'b1;
    wait_ack(1'b1);
    @(posedge clk);
    // Released data shows the inverse so stale bytes cannot pass
    lptDataIn <= ~d;
  endtask
  task recv(output logic [7:0] d, output logic [3:0] n);
    @(posedge clk);
    host_byte_strobe <= 1'b0;
    wait_ack(1'b0);
    repeat (slow) @(posedge clk);
    d = lptDataOut;
    n = statusNibble;
    host_byte_strobe <= 1'b1;
    wait_ack(1'b1);
  endtask
  task init_pulse(input int cyc);
    @(posedge clk);
    hostInit_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    hostInit_n <= 1'b1;
  endtask
endmodule // lpt_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the DSP bus to printer port glue
`timescale 1ns/1ns
`include "host_glue_consts.vh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic wb_ack_o, irq, dspStrobe_n = 1'b1, dspRead = 1'b1, hostDisconnect = 1'b0, demonstration_select = 1'b0;
  logic [23:0] dspAddr = 24'h00_0000;
  logic [7:0] dspDataIn = 8'h00, dspDataOut, lptDataIn, lptDataOut, got, hostByte;
  logic [3:0] statusNibble, gotNib, pins;
  logic dspDataOe, readyOut, readyOe, host_request_interrupt_n, hostRequestInterruptOe, dspReset_n;
  logic user_io_read_select_n, user_io_write_select_n, userIoSelect_n, userMemSelect_n, bootSelect_n;
  logic transceiverEnable_n, transceiverToDsp, host_byte_strobe, hostInit_n, lptDataOe, host_port_acknowledge_n;
  int bad_count = 0, checks = 0;
  always #5 clk = ~clk;
  host_printer_port_glue DUT (.clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq, .dspStrobe_n, .dspRead, .dspAddr, .dspDataIn, .dspDataOut, .dspDataOe, .readyOut,
    .readyOe, .host_request_interrupt_n, .hostRequestInterruptOe, .dspReset_n, .user_io_read_select_n,
    .user_io_write_select_n, .userIoSelect_n, .userMemSelect_n, .bootSelect_n, .transceiverEnable_n,
    .transceiverToDsp, .host_byte_strobe, .hostInit_n, .hostDisconnect, .demonstration_select, .lptDataIn,
    .lptDataOut, .lptDataOe, .statusNibble, .host_port_acknowledge_n);
  lpt_host_model host (.clk, .host_port_acknowledge_n, .statusNibble, .lptDataOut, .host_byte_strobe,
    .hostInit_n, .lptDataIn);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task dsp(input logic [23:0] a, input logic r, input logic [7:0] d);
    @(posedge clk);
    dspStrobe_n <= 1'b0;
    dspAddr <= a;
    dspRead <= r;
    dspDataIn <= d;
    do @(posedge clk); while (readyOut !== 1'b1);
    do @(posedge clk); while (readyOut !== 1'b0);
    got = dspDataOut;
    // Steering as it stood in the last stalled cycle
    pins = {transceiverEnable_n, transceiverToDsp, dspDataOe, lptDataOe};
    dspStrobe_n <= 1'b1;
    dspDataIn <= ~d;
  endtask
  task decode(input logic [3:0] bank, input logic r, input logic [4:0] exp);
    @(posedge clk);
    dspStrobe_n <= 1'b0;
    dspAddr <= {bank, 20'h0_0000};
    dspRead <= r;
    repeat (2) @(posedge clk);
    check({user_io_read_select_n, user_io_write_select_n, userIoSelect_n, userMemSelect_n, bootSelect_n}, exp);
    dspStrobe_n <= 1'b1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(`REG_CTRL, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wb(1'b1, `REG_IRQ_CLR, 32'h0000_0007);
    wb(1'b1, `REG_IRQ_EN, 32'h0000_0007);
    rchk(`REG_IRQ_EN, 32'h0000_0007);
    fork
      host.send(8'hA5);
      dsp(`HOST_BASE, 1'b1, 8'h00);
    join
    check(got, 8'hA5);
    check(pins, 4'b0110);
    fork
      host.recv(hostByte, gotNib);
      dsp(`HOST_TOP, 1'b0, 8'h3C);
    join
    check(gotNib, 4'hC);
    check(pins, 4'b0000);
    wb(1'b1, `REG_CTRL, 32'h0000_0001);
    host.slow = 8;
    fork
      host.recv(hostByte, gotNib);
      dsp(`HOST_BASE + 24'h00_0123, 1'b0, 8'h96);
    join
    check(hostByte, 8'h96);
    check(pins, 4'b0001);
    fork
      host.send(8'h5A);
      dsp(`HOST_BASE, 1'b1, 8'h00);
    join
    check(got, 8'h5A);
    check(pins, 4'b0110);
    rchk(`REG_XFER_CNT, 32'h0000_0004);
    rchk(`REG_IRQ_STAT, 32'h0000_0003);
    check(irq, 1'b1);
    wb(1'b1, `REG_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wb(1'b1, `REG_IRQ_EN, 32'h0000_0007);
    wb(1'b1, `REG_IRQ_CLR, 32'h0000_0003);
    rchk(`REG_IRQ_STAT, 32'h0000_0000);
    check(irq, 1'b0);
    decode(`BANK_BOOT, 1'b1, 5'b11110);
    decode(`BANK_USER_MEM, 1'b1, 5'b11101);
    decode(`BANK_USER_IO, 1'b1, 5'b01011);
    decode(`BANK_USER_IO, 1'b0, 5'b10011);
    // Lamp mode: two selects follow the control bits, the read select still decodes
    wb(1'b1, `REG_CTRL, 32'h0000_0009);
    demonstration_select <= 1'b1;
    repeat (2) @(posedge clk);
    check({userIoSelect_n, bootSelect_n}, 2'b10);
    decode(`BANK_USER_IO, 1'b1, 5'b01110);
    demonstration_select <= 1'b0;
    hostDisconnect <= 1'b1;
    repeat (2) @(posedge clk);
    check({readyOe, hostRequestInterruptOe}, 2'b00);
    hostDisconnect <= 1'b0;
    // Host reset lands in the middle of a stalled access
    fork
      begin
        repeat (3) @(posedge clk);
        host.init_pulse(20);
      end
      dsp(`HOST_BASE, 1'b1, 8'h00);
      begin
        repeat (15) @(posedge clk);
        check(dspReset_n, 1'b0);
      end
    join
    repeat (8) @(posedge clk);
    check({dspReset_n, readyOut}, 2'b10);
    rchk(`REG_IRQ_STAT, 32'h0000_0004);
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test;
  end
endmodule // tb_top
